/* shared/erp_consts.svh */
/*
  constants for the exception return pointer block: register byte
  offsets, field positions, reset values and event bit positions.
  assumes inclusion by bare name from the package and the modules.
*/
`ifndef ERP_CONSTS_SVH
`define ERP_CONSTS_SVH
// How it works
// - enable bit 0 off, 1 on, dispatch-loaded, RW
// - exception entry copies current pointer into saved pointer
// - then state set to 1, jump to handler
// - illegal opcode saves IP, software saves next
// - external halt is asynchronous, no faulting instruction
// - state 1 to 0 reloads pointer from saved
// - handler may rewrite saved pointer before returning
// - saved pointer keeps bits 31:3, low bits zero
`define ERP_OFF_CTRL 8'h00
`define ERP_OFF_SRP 8'h04
`define ERP_OFF_HANDLER 8'h08
`define ERP_OFF_STATUS 8'h0c
`define ERP_OFF_MASK 8'h10
`define ERP_OFF_CAUSE 8'h14
`define ERP_CAUSE_W 2
`define ERP_CTRL_STATE_BIT 0
`define ERP_CTRL_EN_BIT 1
`define ERP_PTR_LOW_MASK 32'hffff_fff8
`define ERP_INSN_STEP 32'h0000_0008
`define ERP_RST_PTR 32'h0000_0000
`define ERP_RST_EN 1'b0
`define ERP_EV_W 4
`define ERP_EV_ILLEGAL 0
`define ERP_EV_SOFTWARE 1
`define ERP_EV_HALT 2
`define ERP_EV_RETURN 3
`define ERP_RST_EV 4'h0
`endif

/* shared/erp_pkg.sv */
/*
  types shared by the exception return pointer block.
  assumes erp_consts.svh is reachable on the include path.
*/
`include "erp_consts.svh"
package erp_pkg;
  typedef enum logic [1:0] {
    ERP_RUN = 2'b00,
    ERP_HANDLER = 2'b01,
    ERP_RETURN = 2'b10
  } erp_state_e;
  typedef enum logic [1:0] {
    ERP_CAUSE_NONE = 2'b00,
    ERP_CAUSE_ILLEGAL = 2'b01,
    ERP_CAUSE_SOFTWARE = 2'b10,
    ERP_CAUSE_HALT = 2'b11
  } erp_cause_e;
  typedef struct packed {
    erp_state_e state;
    logic exc_state;
    logic exc_en;
    logic [31:0] srp;
    logic [31:0] handler;
    erp_cause_e cause;
    logic redirect_valid;
    logic [31:0] redirect_ip;
    logic [`ERP_EV_W-1:0] events;
  } erp_top_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } erp_apb_s;
  typedef struct packed {
    logic [`ERP_EV_W-1:0] status;
    logic [`ERP_EV_W-1:0] mask;
    logic irq;
  } erp_irq_s;
  // pointers hold bits 31:3 only
  function automatic logic [31:0] erp_align(input logic [31:0] v);
    erp_align = v & `ERP_PTR_LOW_MASK;
  endfunction
endpackage

/* shared/erp_if.sv */
/*
  register access carrier between the apb slave and the register owner.
  assumes one clock; write strobe is a single-cycle pulse.
*/
`timescale 1ns/1ps
interface erp_if;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;
  modport bus (output wr, output addr, output wdata, input rdata, input hit);
  modport regs (input wr, input addr, input wdata, output rdata, output hit);
endinterface

/* src/erp_apb.sv */
/*
  apb slave with one wait state; read data and error are registered.
  assumes the register owner answers rdata and hit combinationally.
*/
`timescale 1ns/1ps
`include "erp_consts.svh"
module erp_apb (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register side
  erp_if.bus rb
);
  import erp_pkg::*;
  erp_apb_s r;
  erp_apb_s next_r;
  logic access;
  assign access = psel & penable;
  assign rb.addr = paddr;
  assign rb.wdata = pwdata;
  // write lands only at the edge where pready is seen high
  assign rb.wr = access & r.pready & pwrite & rb.hit;
  always_comb begin
    next_r = r;
    next_r.pready = access & ~r.pready;
    if (access && !r.pready) begin
      next_r.prdata = (pwrite || !rb.hit) ? 32'h0000_0000 : rb.rdata;
      next_r.pslverr = ~rb.hit;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
endmodule

/* src/erp_irq.sv */
/*
  sticky event status, mask and one level interrupt.
  assumes events are one-cycle pulses from the register owner.
*/
`timescale 1ns/1ps
`include "erp_consts.svh"
module erp_irq (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // events and software access
  input wire logic [`ERP_EV_W-1:0] events,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [`ERP_EV_W-1:0] wdata,
  // state
  output logic [`ERP_EV_W-1:0] status,
  output logic [`ERP_EV_W-1:0] mask,
  output logic irq
);
  import erp_pkg::*;
  erp_irq_s r;
  erp_irq_s next_r;
  always_comb begin
    next_r = r;
    // a set in the clearing cycle survives
    if (wr_status) begin
      next_r.status = r.status & ~wdata;
    end
    next_r.status = next_r.status | events;
    if (wr_mask) begin
      next_r.mask = wdata;
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign status = r.status;
  assign mask = r.mask;
  assign irq = r.irq;
endmodule

/* src/erp_top.sv */
/*
  exception entry and return for one thread's instruction pointer:
  saves the return pointer, redirects to the handler, restores on return.
  assumes the execution unit follows redirect_valid on the next cycle and
  that dispatch, cur_ip and exception pulses are synchronous to pclk.
*/
`timescale 1ns/1ps
`include "erp_consts.svh"
module erp_top (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // thread dispatch
  input wire logic dispatch,
  input wire logic dispatch_exc_en,
  // execution unit
  input wire logic [31:0] cur_ip,
  input wire logic exc_illegal,
  input wire logic exc_software,
  input wire logic exc_halt,
  // redirect and state
  output logic redirect_valid,
  output logic [31:0] redirect_ip,
  output logic exc_state,
  output logic exc_enable,
  // interrupt
  output logic irq
);
  import erp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  erp_top_s r;
  erp_top_s next_r;
  erp_if rb ();
  logic [`ERP_EV_W-1:0] ev_status;
  logic [`ERP_EV_W-1:0] ev_mask;
  logic wr_ctrl;
  logic wr_srp;
  logic wr_handler;
  logic wr_status;
  logic wr_mask;
  logic take;
  logic sync_fault;
  logic [31:0] save_ip;
  erp_cause_e save_cause;
  logic ret_req;
  logic [31:0] wr_ptr;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // fixed priority: halt, then illegal, then software
  function automatic erp_cause_e pick_cause(input logic halt, input logic illegal, input logic software);
    pick_cause = ERP_CAUSE_NONE;
    if (halt) begin
      pick_cause = ERP_CAUSE_HALT;
    end else if (illegal) begin
      pick_cause = ERP_CAUSE_ILLEGAL;
    end else if (software) begin
      pick_cause = ERP_CAUSE_SOFTWARE;
    end
  endfunction

  // return point per cause; only bits 31:3 are kept
  function automatic logic [31:0] save_point(input erp_cause_e c, input logic [31:0] ip);
    case (c)
      ERP_CAUSE_SOFTWARE: begin
        // resume after the trapping instruction
        save_point = erp_align(ip + `ERP_INSN_STEP);
      end
      ERP_CAUSE_ILLEGAL: begin
        // retry the faulting instruction
        save_point = erp_align(ip);
      end
      ERP_CAUSE_HALT: begin
        // no faulting instruction: pointer of the interrupted flow
        save_point = erp_align(ip);
      end
      default: begin
        // no cause: never captured, kept aligned anyway
        save_point = erp_align(ip);
      end
    endcase
  endfunction

  // one status bit per cause
  function automatic logic [`ERP_EV_W-1:0] cause_event(input erp_cause_e c);
    cause_event = `ERP_RST_EV;
    case (c)
      ERP_CAUSE_ILLEGAL: begin
        cause_event[`ERP_EV_ILLEGAL] = 1'b1;
      end
      ERP_CAUSE_SOFTWARE: begin
        cause_event[`ERP_EV_SOFTWARE] = 1'b1;
      end
      ERP_CAUSE_HALT: begin
        cause_event[`ERP_EV_HALT] = 1'b1;
      end
      default: begin
        cause_event = `ERP_RST_EV;
      end
    endcase
  endfunction

  // reserved control bits read as zero
  function automatic logic [31:0] ctrl_word(input logic st, input logic en);
    ctrl_word = 32'h0000_0000;
    ctrl_word[`ERP_CTRL_STATE_BIT] = st;
    ctrl_word[`ERP_CTRL_EN_BIT] = en;
  endfunction

  // event registers sit in the low bits of the word
  function automatic logic [31:0] ev_word(input logic [`ERP_EV_W-1:0] v);
    ev_word = 32'h0000_0000;
    ev_word[`ERP_EV_W-1:0] = v;
  endfunction

  // a dispatch starts a fresh thread: enable reloaded, state cleared,
  // pending redirect dropped; srp is left as it was
  function automatic erp_top_s dispatch_load(input erp_top_s s, input logic en);
    dispatch_load = s;
    dispatch_load.exc_en = en;
    dispatch_load.exc_state = 1'b0;
    dispatch_load.state = ERP_RUN;
    dispatch_load.redirect_valid = 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  erp_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rb(rb.bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // write decode

  // one strobe per register except cause; only a completed access gets here
  always_comb begin
    wr_ctrl = 1'b0;
    wr_srp = 1'b0;
    wr_handler = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (rb.wr) begin
      case (rb.addr)
        `ERP_OFF_CTRL: begin
          wr_ctrl = 1'b1;
        end
        `ERP_OFF_SRP: begin
          wr_srp = 1'b1;
        end
        `ERP_OFF_HANDLER: begin
          wr_handler = 1'b1;
        end
        `ERP_OFF_STATUS: begin
          wr_status = 1'b1;
        end
        `ERP_OFF_MASK: begin
          wr_mask = 1'b1;
        end
        default: begin
          wr_ctrl = 1'b0;
        end
      endcase
    end
  end

  // write of a zero state bit; it acts only inside the handler
  assign ret_req = wr_ctrl & ~rb.wdata[`ERP_CTRL_STATE_BIT];
  assign wr_ptr = erp_align(rb.wdata);

  ////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rb.hit = 1'b1;
    rb.rdata = 32'h0000_0000;
    case (rb.addr)
      `ERP_OFF_CTRL: begin
        rb.rdata = ctrl_word(r.exc_state, r.exc_en);
      end
      `ERP_OFF_SRP: begin
        rb.rdata = erp_align(r.srp);
      end
      `ERP_OFF_HANDLER: begin
        rb.rdata = erp_align(r.handler);
      end
      `ERP_OFF_STATUS: begin
        rb.rdata = ev_word(ev_status);
      end
      `ERP_OFF_MASK: begin
        rb.rdata = ev_word(ev_mask);
      end
      `ERP_OFF_CAUSE: begin
        rb.rdata[`ERP_CAUSE_W-1:0] = r.cause;
      end
      default: begin
        // unmapped: error answer with zero data
        rb.hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // exception selection

  // halt outranks the instruction faults; it is never masked by the
  // enable bit since it comes from outside the thread
  assign sync_fault = r.exc_en & (exc_illegal | exc_software);
  // exceptions in the handler or return cycle are dropped
  assign take = (r.state == ERP_RUN) & ~dispatch & (exc_halt | sync_fault);
  assign save_cause = pick_cause(exc_halt, exc_illegal, exc_software);
  assign save_ip = save_point(save_cause, cur_ip);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.redirect_valid = 1'b0;
    next_r.events = `ERP_RST_EV;

    if (wr_handler) begin
      next_r.handler = wr_ptr;
    end

    // handler may retarget the return; hardware capture wins a tie
    if (wr_srp) begin
      next_r.srp = wr_ptr;
    end

    if (wr_ctrl) begin
      next_r.exc_en = rb.wdata[`ERP_CTRL_EN_BIT];
    end

    // entry and return pass through the states in order
    case (r.state)
      ERP_RUN: begin
        if (take) begin
          next_r.srp = save_ip;
          next_r.cause = save_cause;
          next_r.exc_state = 1'b1;
          next_r.redirect_valid = 1'b1;
          next_r.redirect_ip = erp_align(r.handler);
          next_r.state = ERP_HANDLER;
          next_r.events = cause_event(save_cause);
        end
      end
      ERP_HANDLER: begin
        // only a 1 to 0 change returns; writing 1 again is harmless
        if (ret_req) begin
          next_r.exc_state = 1'b0;
          next_r.state = ERP_RETURN;
        end
      end
      ERP_RETURN: begin
        // srp read here so a write in the clearing access is honoured
        next_r.redirect_valid = 1'b1;
        next_r.redirect_ip = erp_align(r.srp);
        next_r.events[`ERP_EV_RETURN] = 1'b1;
        next_r.state = ERP_RUN;
      end
      default: begin
        next_r.state = ERP_RUN;
        next_r.exc_state = 1'b0;
      end
    endcase

    // dispatch beats the bus and the exception inputs
    if (dispatch) begin
      next_r = dispatch_load(next_r, dispatch_exc_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  // srp has no meaningful reset value; zero is only for determinism
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state <= ERP_RUN;
      r.exc_state <= 1'b0;
      r.exc_en <= `ERP_RST_EN;
      r.srp <= `ERP_RST_PTR;
      r.handler <= `ERP_RST_PTR;
      r.cause <= ERP_CAUSE_NONE;
      r.redirect_valid <= 1'b0;
      r.redirect_ip <= `ERP_RST_PTR;
      r.events <= `ERP_RST_EV;
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  // status and mask live in the interrupt block
  erp_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .events(r.events),
    .wr_status(wr_status),
    .wr_mask(wr_mask),
    .wdata(rb.wdata[`ERP_EV_W-1:0]),
    .status(ev_status),
    .mask(ev_mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // plain flops, no logic after them
  assign redirect_valid = r.redirect_valid;
  assign redirect_ip = r.redirect_ip;
  assign exc_state = r.exc_state;
  assign exc_enable = r.exc_en;
endmodule

/* testbench/erp_top_asserts.sv */
/*
  port-level checker for erp_top.
  assumes one clock and binding by the bind below.
*/
`timescale 1ns/1ps
module erp_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // thread side
  input wire logic dispatch,
  input wire logic dispatch_exc_en,
  input wire logic exc_halt,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_ip,
  input wire logic exc_state,
  input wire logic exc_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // fell state means a return is still pending, so no entry then
  a_halt_entry:
    assert property (ce && exc_halt && !dispatch && !exc_state && !$fell(exc_state) |=> redirect_valid && exc_state)
      else $error("halt not taken");
  a_enable_gate:
    assert property (ce && !exc_enable && !exc_halt && !dispatch && !exc_state && !$fell(exc_state)
      |=> !redirect_valid) else $error("entry while disabled");
  a_ptr_aligned:
    assert property (redirect_valid |-> redirect_ip[2:0] == 3'h0) else $error("unaligned redirect");
  a_return_redirect:
    assert property (ce && $fell(exc_state) && !dispatch && !$past(dispatch) |=> redirect_valid)
      else $error("no return redirect");
  a_handler_quiet:
    assert property (ce && exc_state |=> !redirect_valid) else $error("redirect inside handler");
  a_state_held:
    assert property (ce && exc_state && !pready && !dispatch |=> exc_state) else $error("state lost");
  a_dispatch_load:
    assert property (ce && dispatch |=> !exc_state && exc_enable == $past(dispatch_exc_en))
      else $error("dispatch load");
  a_ready_pulse:
    assert property (ce && pready |=> !pready) else $error("pready too long");
  a_ready_wait:
    assert property (ce && psel && penable && !pready |=> pready) else $error("pready late");
  a_err_zero:
    assert property (pslverr |-> prdata == 32'h0) else $error("error data");
endmodule
bind erp_top erp_chk i_erp_chk (.pclk, .presetn, .ce, .psel, .penable, .prdata, .pready, .pslverr,
  .dispatch, .dispatch_exc_en, .exc_halt, .redirect_valid, .redirect_ip, .exc_state, .exc_enable);

/* testbench/test_exception_return_pointer.sv */
/*
  bench for erp_top: apb tasks, exception pulses, dispatch.
  assumes the checker binds itself.
*/
`timescale 1ns/1ps
`include "erp_consts.svh"
module test_exception_return_pointer;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic dispatch = 1'h0;
  logic dispatch_exc_en = 1'h0;
  logic exc_illegal = 1'h0;
  logic exc_software = 1'h0;
  logic exc_halt = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] cur_ip = 32'h0;
  logic [31:0] prdata, redirect_ip, rd;
  logic pready, pslverr, redirect_valid, exc_state, exc_enable, irq, err;
  logic [31:0] srp_exp [3] = '{32'ha08, 32'ha10, 32'ha08};
  int fails = 0;
  int comparisons = 0;
  erp_top i_erp_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dispatch, .dispatch_exc_en, .cur_ip, .exc_illegal, .exc_software,
    .exc_halt, .redirect_valid, .redirect_ip, .exc_state, .exc_enable, .irq);
  initial begin
    forever #2 pclk = ~pclk;
  end
//////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // no wait count assumed: only the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task exc(input int k);
    @(posedge pclk);
    cur_ip <= 32'ha0f;
    {exc_halt, exc_software, exc_illegal} <= 3'h1 << k;
    @(posedge pclk);
    {exc_halt, exc_software, exc_illegal} <= 3'h0;
    #1;
  endtask
  task disp(input logic e);
    @(posedge pclk);
    dispatch <= 1'h1;
    dispatch_exc_en <= e;
    @(posedge pclk);
    dispatch <= 1'h0;
    #1;
  endtask
  task complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
//////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rchk(`ERP_OFF_CTRL, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("reset test done");
    disp(1'h1);
    chk(exc_enable, 32'h1);
    apb(1'h1, `ERP_OFF_CTRL, 32'h0);
    rchk(`ERP_OFF_CTRL, 32'h0);
    apb(1'h1, `ERP_OFF_CTRL, 32'h2);
    rchk(`ERP_OFF_CTRL, 32'h2);
    apb(1'h1, `ERP_OFF_HANDLER, 32'h1234);
    rchk(`ERP_OFF_HANDLER, 32'h1230);
    apb(1'h1, `ERP_OFF_MASK, 32'hf);
    $display("dispatch test done");
    for (int k = 0; k < 3; k++) begin
      exc(k);
      chk(redirect_valid, 32'h1);
      chk(redirect_ip, 32'h1230);
      chk(exc_state, 32'h1);
      @(posedge pclk);
      #1 chk(irq, 32'h1);
      rchk(`ERP_OFF_SRP, srp_exp[k]);
      rchk(`ERP_OFF_CAUSE, k + 1);
      rchk(`ERP_OFF_CTRL, 32'h3);
      if (k == 0) begin
        apb(1'h1, `ERP_OFF_SRP, 32'h2004);
        srp_exp[0] = 32'h2000;
      end
      apb(1'h1, `ERP_OFF_CTRL, 32'h2);
      @(posedge pclk);
      #1 chk(redirect_valid, 32'h1);
      chk(redirect_ip, srp_exp[k]);
      chk(exc_state, 32'h0);
      rchk(`ERP_OFF_STATUS, (32'h1 << k) | 32'h8);
      apb(1'h1, `ERP_OFF_STATUS, 32'hf);
    end
    $display("entry and return test done");
    apb(1'h1, `ERP_OFF_CTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      exc(k);
      chk(redirect_valid, 32'h0);
      chk(exc_state, 32'h0);
    end
    apb(1'h1, `ERP_OFF_MASK, 32'h0);
    exc(2);
    chk(exc_state, 32'h1);
    repeat (2) @(posedge pclk);
    #1 chk(irq, 32'h0);
    rchk(`ERP_OFF_STATUS, 32'h4);
    apb(1'h1, `ERP_OFF_MASK, 32'h4);
    @(posedge pclk);
    #1 chk(irq, 32'h1);
    apb(1'h1, `ERP_OFF_STATUS, 32'h4);
    @(posedge pclk);
    #1 chk(irq, 32'h0);
    disp(1'h0);
    chk(exc_state, 32'h0);
    chk(exc_enable, 32'h0);
    $display("gate and mask test done");
    complete_run;
  end
endmodule
